//--- rac_bank.sv
`timescale 1ns/1ps
// Function
// (RULE1) A read/write bit reads back the value last written to it.
// (RULE2) A read-only bit ignores writes and keeps its value.
// (RULE3) A write-only bit accepts writes but reads back an undefined value.
// (RULE4) Reserved bits always read as zero.
// (RULE5) Software writes zero to reserved bits.
// (RULE6) A soft reset restores reset values except in the debug register.
// (RULE7) Base and its set/clear/toggle registers all read the base contents.
// (RULE8) Ones written to the clear register force base bits to zero.
// (RULE9) Ones written to the set register force base bits to one.
// (RULE10) Ones written to the toggle register invert base bits.
// (RULE11) Zeros written through set, clear or toggle leave base bits unchanged.
module rac_bank
  import rac_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [RAC_AW-1:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // block state and control
  input wire logic [7:0] status_in,
  output logic [7:0] ctrl_out,
  output logic [7:0] cmd_out,
  output logic [7:0] pair_out,
  output logic [7:0] dbg_out
);
  import rac_pkg::*;

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  logic [7:0] dbg_r;
  logic [7:0] dbg_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic sw_rst;
  rac_pair_if pif ();

  // ----------------------------------------
  // soft reset
  // ----------------------------------------
  // cmd bit 7 is a write-only soft reset strobe
  assign sw_rst = wr_en && addr == RAC_OFF_CMD && wdata[7];

  always_comb begin
    ctrl_nxt = ctrl_r;
    cmd_nxt = cmd_r;
    dbg_nxt = dbg_r;
    if (sw_rst) begin
      ctrl_nxt = RAC_CTRL_RST; // see (RULE6)
      cmd_nxt = 8'h00;
    end else if (wr_en) begin
      unique case (addr)
        RAC_OFF_CTRL: ctrl_nxt = wdata & RAC_CTRL_MASK; // see (RULE1) see (RULE4)
        RAC_OFF_CMD: cmd_nxt = wdata; // see (RULE3)
        RAC_OFF_DBG: dbg_nxt = wdata & RAC_DBG_MASK;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // pair decode
  // ----------------------------------------
  assign pif.wr = wr_en && (addr == RAC_OFF_BASE || addr == RAC_OFF_SET ||
                            addr == RAC_OFF_CLEAR || addr == RAC_OFF_TOGGLE);
  assign pif.mask = wdata;
  always_comb begin
    unique case (addr)
      RAC_OFF_SET: pif.op = RAC_OP_SET;
      RAC_OFF_CLEAR: pif.op = RAC_OP_CLEAR;
      RAC_OFF_TOGGLE: pif.op = RAC_OP_TOGGLE;
      default: pif.op = RAC_OP_NONE;
    endcase
  end

  rac_pair u_pair (
    .clk(clk),
    .reset_n(reset_n),
    .sw_rst(sw_rst), // see (RULE6)
    .port(pif.pair)
  );

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_en) begin
      unique case (addr)
        RAC_OFF_CTRL: rdata_nxt = ctrl_r; // see (RULE1)
        RAC_OFF_STAT: rdata_nxt = status_in; // see (RULE2)
        RAC_OFF_CMD: rdata_nxt = RAC_UNDEF_RD; // see (RULE3)
        RAC_OFF_DBG: rdata_nxt = dbg_r & RAC_DBG_MASK; // see (RULE4)
        default: rdata_nxt = pif.value; // see (RULE7)
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= RAC_CTRL_RST;
      cmd_r <= 8'h00;
      dbg_r <= RAC_DBG_RST;
      rdata_r <= 8'h00;
    end else begin
      ctrl_r <= ctrl_nxt;
      cmd_r <= cmd_nxt;
      dbg_r <= dbg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata = rdata_r;
  assign ctrl_out = ctrl_r;
  assign cmd_out = cmd_r;
  assign pair_out = pif.value;
  assign dbg_out = dbg_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_rw_readback: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE1)
    wr_en && addr == RAC_OFF_CTRL && !sw_rst ##1 rd_en && addr == RAC_OFF_CTRL && !wr_en
    |=> rdata == ($past(wdata, 2) & RAC_CTRL_MASK))
    else $error("ctrl readback mismatch");
  chk_dbg_readback: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE1)
    wr_en && addr == RAC_OFF_DBG |=> dbg_r == ($past(wdata) & RAC_DBG_MASK))
    else $error("dbg write not stored");
  chk_ctrl_only_written: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE1)
    !(wr_en && addr == RAC_OFF_CTRL) && !sw_rst |=> ctrl_r == $past(ctrl_r))
    else $error("ctrl changed without write");
  chk_pair_base_write: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE1)
    wr_en && addr == RAC_OFF_BASE |=> pair_out == $past(wdata))
    else $error("base write not stored");
  chk_rdata_holds: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE1)
    !rd_en |=> $stable(rdata))
    else $error("read data moved without read");

  chk_ro_status: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE2)
    rd_en && addr == RAC_OFF_STAT |=> rdata == $past(status_in))
    else $error("status read wrong");
  chk_stat_write_ignored: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE2)
    wr_en && addr == RAC_OFF_STAT
    |=> ctrl_r == $past(ctrl_r) && cmd_r == $past(cmd_r) && dbg_r == $past(dbg_r))
    else $error("status write had an effect");

  chk_cmd_read_const: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE3)
    rd_en && addr == RAC_OFF_CMD |=> rdata == RAC_UNDEF_RD)
    else $error("cmd read leaked contents");
  chk_cmd_write_kept: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE3)
    wr_en && addr == RAC_OFF_CMD && !wdata[7] |=> cmd_out == $past(wdata))
    else $error("cmd write not stored");

  chk_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE4)
    (ctrl_r & ~RAC_CTRL_MASK) == 8'h00 && (dbg_r & ~RAC_DBG_MASK) == 8'h00)
    else $error("reserved bits not zero");
  chk_ctrl_read_resv: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE4)
    rd_en && addr == RAC_OFF_CTRL |=> (rdata & ~RAC_CTRL_MASK) == 8'h00)
    else $error("ctrl read shows reserved bits");
  chk_dbg_read_resv: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE4)
    rd_en && addr == RAC_OFF_DBG |=> (rdata & ~RAC_DBG_MASK) == 8'h00)
    else $error("dbg read shows reserved bits");
  for (genvar b = 0; b < 8; b++) begin : g_ctrl_resv
    if (!RAC_CTRL_MASK[b]) begin : g_bit
      chk_ctrl_resv_bit: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE4)
        !ctrl_out[b])
        else $error("ctrl reserved bit set");
    end
  end

  chk_softrst_vals: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE6)
    sw_rst |=> ctrl_r == RAC_CTRL_RST && pair_out == RAC_BASE_RST && dbg_r == $past(dbg_r))
    else $error("soft reset values wrong");
  chk_softrst_cmd: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE6)
    sw_rst |=> cmd_r == 8'h00)
    else $error("soft reset left cmd set");
  chk_dbg_only_written: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE6)
    !(wr_en && addr == RAC_OFF_DBG) |=> dbg_r == $past(dbg_r))
    else $error("dbg changed without write");
  chk_dbg_swrst_kept: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE6)
    sw_rst |=> dbg_out == $past(dbg_out))
    else $error("soft reset touched dbg");

  chk_pair_same_read: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE7)
    rd_en && addr >= RAC_OFF_BASE |=> rdata == $past(pair_out))
    else $error("pair read differs");
  chk_set_read_same: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE7)
    rd_en && addr == RAC_OFF_SET |=> rdata == $past(pair_out))
    else $error("set register read differs");
  chk_toggle_read_same: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE7)
    rd_en && addr == RAC_OFF_TOGGLE |=> rdata == $past(pair_out))
    else $error("toggle register read differs");
  chk_read_no_side: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE7)
    rd_en && !wr_en |=> pair_out == $past(pair_out) && ctrl_r == $past(ctrl_r))
    else $error("read changed a register");

  chk_pair_idle_kept: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE11)
    !pif.wr && !sw_rst |=> pair_out == $past(pair_out))
    else $error("base changed without write");

  // ----------------------------------------
  // coverage
  // ----------------------------------------
  cov_set: cover property (@(posedge clk) wr_en && addr == RAC_OFF_SET && wdata != 8'h00);
  cov_clear: cover property (@(posedge clk) wr_en && addr == RAC_OFF_CLEAR && wdata != 8'h00);
  cov_toggle: cover property (@(posedge clk) wr_en && addr == RAC_OFF_TOGGLE && wdata != 8'h00);
  cov_swrst: cover property (@(posedge clk) sw_rst);
  cov_pair_read: cover property (@(posedge clk) rd_en && addr >= RAC_OFF_BASE);
endmodule

//--- rac_pair.sv
`timescale 1ns/1ps
module rac_pair
  import rac_pkg::*;
(
  // clock and resets
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sw_rst,
  // strobe side
  rac_pair_if.pair port
);
  logic [7:0] base_r;
  logic [7:0] base_nxt;

  always_comb begin
    base_nxt = base_r;
    if (sw_rst) begin
      base_nxt = RAC_BASE_RST;
    end else if (port.wr) begin
      unique case (port.op)
        RAC_OP_SET: base_nxt = base_r | port.mask; // see (RULE9) see (RULE11)
        RAC_OP_CLEAR: base_nxt = base_r & ~port.mask; // see (RULE8) see (RULE11)
        RAC_OP_TOGGLE: base_nxt = base_r ^ port.mask; // see (RULE10) see (RULE11)
        RAC_OP_NONE: base_nxt = port.mask;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base_r <= RAC_BASE_RST;
    end else begin
      base_r <= base_nxt;
    end
  end

  assign port.value = base_r;

  chk_set_forces_one: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE9)
    port.wr && !sw_rst && port.op == RAC_OP_SET |=> (base_r & $past(port.mask)) == $past(port.mask))
    else $error("set did not force ones");
  chk_clear_forces_zero: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE8)
    port.wr && !sw_rst && port.op == RAC_OP_CLEAR |=> (base_r & $past(port.mask)) == 8'h00)
    else $error("clear did not force zeros");
  chk_toggle_inverts_bits: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE10)
    port.wr && !sw_rst && port.op == RAC_OP_TOGGLE
    |=> base_r == ($past(base_r) ^ $past(port.mask)))
    else $error("toggle result wrong");
  chk_zero_keeps_bits: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE11)
    port.wr && !sw_rst && port.op != RAC_OP_NONE
    |=> (base_r & ~$past(port.mask)) == ($past(base_r) & ~$past(port.mask)))
    else $error("unmasked bits changed");
endmodule

//--- rac_pair_if.sv
`timescale 1ns/1ps
interface rac_pair_if;
  import rac_pkg::*;
  logic wr;
  rac_op_type op;
  logic [7:0] mask;
  logic [7:0] value;
  modport bank (output wr, output op, output mask, input value);
  modport pair (input wr, input op, input mask, output value);
endinterface

//--- rac_pkg.sv
package rac_pkg;
  // register map of the generic bank, byte offsets on the local port
  localparam int RAC_AW = 3;
  localparam logic [2:0] RAC_OFF_CTRL = 3'h0;
  localparam logic [2:0] RAC_OFF_STAT = 3'h1;
  localparam logic [2:0] RAC_OFF_CMD = 3'h2;
  localparam logic [2:0] RAC_OFF_DBG = 3'h3;
  localparam logic [2:0] RAC_OFF_BASE = 3'h4;
  localparam logic [2:0] RAC_OFF_SET = 3'h5;
  localparam logic [2:0] RAC_OFF_CLEAR = 3'h6;
  localparam logic [2:0] RAC_OFF_TOGGLE = 3'h7;
  // field layout
  localparam logic [7:0] RAC_CTRL_MASK = 8'h3F;
  localparam logic [7:0] RAC_DBG_MASK = 8'h0F;
  // reset values
  localparam logic [7:0] RAC_CTRL_RST = 8'h00;
  localparam logic [7:0] RAC_DBG_RST = 8'h00;
  localparam logic [7:0] RAC_BASE_RST = 8'h00;
  localparam logic [7:0] RAC_UNDEF_RD = 8'h00;
  typedef enum logic [1:0] {RAC_OP_SET, RAC_OP_CLEAR, RAC_OP_TOGGLE, RAC_OP_NONE} rac_op_type;
endpackage

//--- tb_register_access_conventions.sv
`timescale 1ns/1ps
module tb_register_access_conventions;
  import rac_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [RAC_AW-1:0] addr = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] status_in = 8'hC3;
  logic [7:0] rdata, ctrl_out, cmd_out, pair_out, dbg_out;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  rac_bank u_dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wdata(wdata), .rdata(rdata), .status_in(status_in), .ctrl_out(ctrl_out),
    .cmd_out(cmd_out), .pair_out(pair_out), .dbg_out(dbg_out));
  initial begin
    forever #20 clk = ~clk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [RAC_AW-1:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input string what, input logic [RAC_AW-1:0] a, input logic [7:0] exp);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    check(what, exp, rdata);
    @(negedge clk);
  endtask
  task automatic summarize();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_plain_access();
    wr(RAC_OFF_CTRL, 8'h15);
    rd("ctrl", RAC_OFF_CTRL, 8'h15);
    wr(RAC_OFF_CTRL, 8'hFF);
    check("ctrl_out", 8'hFF & RAC_CTRL_MASK, ctrl_out);
    rd("ctrl resv", RAC_OFF_CTRL, 8'hFF & RAC_CTRL_MASK);
    wr(RAC_OFF_DBG, 8'hFA);
    rd("dbg resv", RAC_OFF_DBG, 8'hFA & RAC_DBG_MASK);
    rd("stat", RAC_OFF_STAT, 8'hC3);
    wr(RAC_OFF_STAT, 8'h3C);
    rd("stat kept", RAC_OFF_STAT, 8'hC3);
    status_in = 8'h5A;
    rd("stat live", RAC_OFF_STAT, 8'h5A);
    wr(RAC_OFF_CMD, 8'h55);
    check("cmd_out", 8'h55, cmd_out);
    rd("cmd read", RAC_OFF_CMD, RAC_UNDEF_RD);
  endtask
  task automatic t_pair();
    wr(RAC_OFF_BASE, 8'hA5);
    // back-to-back set, clear, toggle, then zero writes
    addr = RAC_OFF_SET;
    wdata = 8'h0A;
    wr_en = 1'b1;
    @(negedge clk);
    check("after set", 8'hAF, pair_out);
    addr = RAC_OFF_CLEAR;
    wdata = 8'h81;
    @(negedge clk);
    check("after clear", 8'h2E, pair_out);
    addr = RAC_OFF_TOGGLE;
    wdata = 8'hF0;
    @(negedge clk);
    check("after toggle", 8'hDE, pair_out);
    wdata = 8'h00;
    for (int i = 5; i < 8; i++) begin
      addr = 3'(i);
      @(negedge clk);
      check("zero write", 8'hDE, pair_out);
    end
    wr_en = 1'b0;
    @(negedge clk);
    for (int i = 4; i < 8; i++) begin
      rd("pair read", 3'(i), 8'hDE);
    end
  endtask
  task automatic t_soft_reset();
    wr(RAC_OFF_CMD, 8'h80);
    @(negedge clk);
    check("ctrl soft", RAC_CTRL_RST, ctrl_out);
    check("cmd soft", 8'h00, cmd_out);
    check("base soft", RAC_BASE_RST, pair_out);
    check("dbg kept", 8'h0A, dbg_out);
    rd("base read", RAC_OFF_BASE, RAC_BASE_RST);
  endtask
  // ----------------------------------------
  // sequence and timeout
  // ----------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    check("ctrl rst", RAC_CTRL_RST, ctrl_out);
    check("dbg rst", RAC_DBG_RST, dbg_out);
    t_plain_access();
    t_pair();
    t_soft_reset();
    summarize();
  end
endmodule
